//--- rtl/svdc_pkg.sv
package svdc_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_MHZ            = 50;
	localparam int PRI_FALL_DELAY_US  = 500;
	localparam int SEC_STAB_US        = 500;
	localparam int POR_STAB_MS        = 4;
	// delay counts, exact at 50 MHz
	localparam int PRI_FALL_CYCLES    = PRI_FALL_DELAY_US * CLK_MHZ;
	localparam int SEC_STAB_CYCLES    = SEC_STAB_US * CLK_MHZ;
	localparam int POR_STAB_CYCLES    = POR_STAB_MS * 1000 * CLK_MHZ;
	localparam int RESET_PROC_CYCLES  = 16;

	// ************************************************************
	// boot option setting
	// ************************************************************
	localparam logic [19:0] OPTION_ADDR    = 20'h000c1;
	localparam int          PRI_LEVEL_W    = 3;
	localparam int          OPT_LEVEL_LSB  = 0;
	localparam int          OPT_MODE_BIT   = 3;
	localparam int          PRI_LEVEL_COUNT = 6;
	localparam logic        MODE_RESET     = 1'b1;
	localparam logic        MODE_IRQ       = 1'b0;

	// ************************************************************
	// register map (byte offsets)
	// ************************************************************
	localparam logic [11:0] DETECT_CTRL_OFS  = 12'h000;
	localparam logic [11:0] LEVEL_SELECT_OFS = 12'h004;
	localparam logic [11:0] FLAG_STATUS_OFS  = 12'h008;
	localparam logic [11:0] FLAG_CLEAR_OFS   = 12'h00c;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int          CTRL_UNLOCK_BIT    = 0;
	localparam int          LVL_CODE_LSB       = 0;
	localparam int          SEC_LEVEL_W        = 5;
	localparam int          LVL_MODE_BIT       = 6;
	localparam int          LVL_ENABLE_BIT     = 7;
	localparam logic [4:0]  SEC_LEVEL_COUNT    = 5'h12;
	localparam int          FLG_PRI_BIT        = 0;
	localparam int          FLG_SEC_BIT        = 1;
	localparam int          STS_PRI_OK_BIT     = 2;
	localparam int          STS_SEC_ACTIVE_BIT = 3;
	localparam int          STS_PRI_RSTMODE_BIT = 4;
	localparam logic        UNLOCK_RST         = 1'b0;
	localparam logic [4:0]  SEC_LEVEL_RST      = 5'h00;

	// ************************************************************
	// reset sequencer states
	// ************************************************************
	typedef enum logic [1:0]
	{
		ST_STAB        = 2'b00,
		ST_WAIT_SUPPLY = 2'b01,
		ST_PROC        = 2'b10,
		ST_RUN         = 2'b11
	} svdc_rst_state_t;

endpackage : svdc_pkg

//--- rtl/svdc_sync.sv
`timescale 1ns/10ps
module svdc_sync
	import svdc_pkg::*;
#(
	parameter int WIDTH = 2
)
(
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	// ************************************************************
	// two flip-flops per bit
	// ************************************************************
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		logic meta_reg;
		logic sync_reg;

		// first stage feeds only the second stage
		always_ff @(posedge clk_in)
		begin
			if (sys_rst_in)
			begin
				meta_reg <= 1'b0;
				sync_reg <= 1'b0;
			end
			else
			begin
				meta_reg <= d_in[i];
				sync_reg <= meta_reg;
			end
		end

		assign q_out[i] = sync_reg;
	end

endmodule : svdc_sync

//--- rtl/svdc_timer.sv
`timescale 1ns/10ps
module svdc_timer
	import svdc_pkg::*;
#(
	parameter int CYCLES = RESET_PROC_CYCLES
)
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// run level and elapsed indication
	input  wire logic run_in,
	output logic      done_out
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_reg;

	// counts while run is held, restarts when it drops, saturates at the end
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			count_reg <= '0;
		else if (!run_in)
			count_reg <= '0;
		else if (count_reg != CW'(CYCLES))
			count_reg <= count_reg + 1'b1;
	end

	assign done_out = run_in & (count_reg == CW'(CYCLES));

endmodule : svdc_timer

//--- rtl/svdc_top.sv
// Behaviour
// - primary mode and level from boot option
// - reset held until primary supply detected
// - reset mode: low supply asserts internal reset
// - interrupt mode: irq on each primary crossing
// - primary falling detection delayed 500 us
// - secondary detector off after every reset
// - level register writable only while unlocked
// - level rewrite accepted once per reset
// - secondary silent until 500 us stabilisation
// - secondary level code selects eighteen levels
// - secondary reset mode resets, clears level register
// - re-enabling below threshold cycles reset again
// - secondary irq: first low, then crossings
// - run only after stabilisation plus processing
// - no secondary event if supply already good
// - primary irq meaningless in forbidden pairing
// - detection flags set, cleared by clear bits
// - secondary reset forces primary into reset mode
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module svdc_top
	import svdc_pkg::*;
#(
	parameter int PRI_FALL_CYC = PRI_FALL_CYCLES,
	parameter int SEC_STAB_CYC = SEC_STAB_CYCLES,
	parameter int POR_STAB_CYC = POR_STAB_CYCLES
)
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// boot option setting
	input  wire logic [7:0]  boot_option_in,
	// analog comparators, high while supply at or above threshold
	input  wire logic        pri_cmp_in,
	input  wire logic        sec_cmp_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// analog settings
	output logic      [2:0]  primary_level_out,
	output logic             secondary_enable_out,
	output logic      [4:0]  secondary_level_out,
	// reset and interrupt events
	output logic             internal_rst_out,
	output logic             low_voltage_irq_out,
	output logic             voltage_detect_irq_out
);

	// ************************************************************
	// declarations
	// ************************************************************
	svdc_rst_state_t  state_reg;
	logic [1:0]       cmp_sync;
	logic             pri_sync;
	logic             sec_sync;
	logic             pri_mode_reg;
	logic [2:0]       pri_level_reg;
	logic             pri_ok_reg;
	logic             pri_prev_reg;
	logic             pri_fall_done;
	logic             force_pri_rst_reg;
	logic             pri_rst_mode;
	logic             por_done;
	logic             proc_done;
	logic             soft_rst;
	logic             cpu_run;
	logic             unlock_reg;
	logic             sec_enable_reg;
	logic             sec_mode_reg;
	logic [4:0]       sec_code_reg;
	logic             written_once_reg;
	logic             sec_active;
	logic             sec_prev_reg;
	logic             sec_rst_req;
	logic             pri_irq;
	logic             sec_irq;
	logic             pri_flag_reg;
	logic             sec_flag_reg;
	logic             pri_irq_reg;
	logic             sec_irq_reg;
	logic             acc;
	logic             wr;
	logic             sel_ctrl;
	logic             sel_level;
	logic             sel_status;
	logic             sel_clear;
	logic             lvl_wr_ok;
	logic             clr_pri;
	logic             clr_sec;
	logic [31:0]      rdata;

	// ************************************************************
	// comparator synchronisers and timers
	// ************************************************************
	// both comparator levels cross into clk_in before any use
	svdc_sync #(.WIDTH(2)) u_sync
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.d_in       ({sec_cmp_in, pri_cmp_in}),
		.q_out      (cmp_sync)
	);

	assign pri_sync = cmp_sync[0];
	assign sec_sync = cmp_sync[1];

	// primary low level must persist before it counts
	svdc_timer #(.CYCLES(PRI_FALL_CYC)) u_fall_tmr
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (pri_ok_reg & ~pri_sync),
		.done_out   (pri_fall_done)
	);

	// power-on stabilisation time
	svdc_timer #(.CYCLES(POR_STAB_CYC)) u_por_tmr
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (state_reg == ST_STAB),
		.done_out   (por_done)
	);

	// reset processing time
	svdc_timer #(.CYCLES(RESET_PROC_CYCLES)) u_proc_tmr
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (state_reg == ST_PROC),
		.done_out   (proc_done)
	);

	// secondary stabilisation after enable
	svdc_timer #(.CYCLES(SEC_STAB_CYC)) u_stab_tmr
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (sec_enable_reg),
		.done_out   (sec_active)
	);

	// ************************************************************
	// primary detector
	// ************************************************************
	// boot option caught while the power-on wait runs
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pri_mode_reg  <= MODE_RESET;
			pri_level_reg <= '0;
		end
		else if (state_reg == ST_STAB)
		begin
			pri_mode_reg  <= boot_option_in[OPT_MODE_BIT];
			pri_level_reg <= boot_option_in[OPT_LEVEL_LSB +: PRI_LEVEL_W];
		end
	end

	// rise is taken at once, fall only after the delay
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			pri_ok_reg <= 1'b0;
		else if (pri_sync)
			pri_ok_reg <= 1'b1;
		else if (pri_fall_done)
			pri_ok_reg <= 1'b0;
	end

	// previous filtered level for crossing detection
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			pri_prev_reg <= 1'b0;
		else
			pri_prev_reg <= pri_ok_reg;
	end

	// a secondary reset leaves the primary in reset mode until power-on
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			force_pri_rst_reg <= 1'b0;
		else if (sec_rst_req)
			force_pri_rst_reg <= 1'b1;
	end

	assign pri_rst_mode = (pri_mode_reg == MODE_RESET) | force_pri_rst_reg;
	// crossing reported in interrupt mode; in a forbidden pairing it may be noise
	assign pri_irq = cpu_run & ~pri_rst_mode & (pri_ok_reg != pri_prev_reg);

	// ************************************************************
	// reset sequencer
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			state_reg <= ST_STAB;
		else
		begin
			unique case (state_reg)
				ST_STAB:
					if (por_done)
						state_reg <= ST_WAIT_SUPPLY;
				ST_WAIT_SUPPLY:
					if (pri_ok_reg)
						state_reg <= ST_PROC;
				ST_PROC:
					if (!pri_ok_reg)
						state_reg <= ST_WAIT_SUPPLY;
					else if (proc_done)
						state_reg <= ST_RUN;
				ST_RUN:
					if ((pri_rst_mode & ~pri_ok_reg) | sec_rst_req)
						state_reg <= ST_WAIT_SUPPLY;
			endcase
		end
	end

	assign cpu_run          = (state_reg == ST_RUN);
	assign internal_rst_out = ~cpu_run;
	// any internal reset reinitialises the unlock bit, the level register and the flags
	assign soft_rst         = sys_rst_in | ~cpu_run;

	// ************************************************************
	// apb decode
	// ************************************************************
	assign acc         = psel_in & penable_in;
	assign wr          = acc & pwrite_in;
	assign sel_ctrl    = (paddr_in == DETECT_CTRL_OFS);
	assign sel_level   = (paddr_in == LEVEL_SELECT_OFS);
	assign sel_status  = (paddr_in == FLAG_STATUS_OFS);
	assign sel_clear   = (paddr_in == FLAG_CLEAR_OFS);
	assign pready_out  = 1'b1;
	assign pslverr_out = acc & ~(sel_ctrl | sel_level | sel_status | sel_clear);
	assign clr_pri     = wr & sel_clear & pwdata_in[FLG_PRI_BIT];
	assign clr_sec     = wr & sel_clear & pwdata_in[FLG_SEC_BIT];

	// level write needs unlock, an unused rewrite and a legal code
	assign lvl_wr_ok = wr & sel_level & unlock_reg & ~written_once_reg
		& (pwdata_in[LVL_CODE_LSB +: SEC_LEVEL_W] < SEC_LEVEL_COUNT);

	// ************************************************************
	// registers
	// ************************************************************
	// write-unlock bit
	always_ff @(posedge clk_in)
	begin
		if (soft_rst)
			unlock_reg <= UNLOCK_RST;
		else if (wr & sel_ctrl)
			unlock_reg <= pwdata_in[CTRL_UNLOCK_BIT];
	end

	// level select, cleared by every internal reset
	always_ff @(posedge clk_in)
	begin
		if (soft_rst)
		begin
			sec_enable_reg   <= 1'b0;
			sec_mode_reg     <= MODE_IRQ;
			sec_code_reg     <= SEC_LEVEL_RST;
			written_once_reg <= 1'b0;
		end
		else if (lvl_wr_ok)
		begin
			sec_enable_reg   <= pwdata_in[LVL_ENABLE_BIT];
			sec_mode_reg     <= pwdata_in[LVL_MODE_BIT];
			sec_code_reg     <= pwdata_in[LVL_CODE_LSB +: SEC_LEVEL_W];
			written_once_reg <= 1'b1;
		end
	end

	// ************************************************************
	// secondary detector
	// ************************************************************
	// assumed good at activation, so an initial low reports once
	always_ff @(posedge clk_in)
	begin
		if (soft_rst | ~sec_active)
			sec_prev_reg <= 1'b1;
		else
			sec_prev_reg <= sec_sync;
	end

	assign sec_irq     = cpu_run & sec_active & (sec_mode_reg == MODE_IRQ)
		& (sec_sync != sec_prev_reg);
	assign sec_rst_req = cpu_run & sec_active & (sec_mode_reg == MODE_RESET)
		& ~sec_sync;

	// ************************************************************
	// flags and interrupt pulses
	// ************************************************************
	// a set arriving with its clear wins
	always_ff @(posedge clk_in)
	begin
		if (soft_rst)
		begin
			pri_flag_reg <= 1'b0;
			sec_flag_reg <= 1'b0;
		end
		else
		begin
			pri_flag_reg <= pri_irq | (pri_flag_reg & ~clr_pri);
			sec_flag_reg <= sec_irq | (sec_flag_reg & ~clr_sec);
		end
	end

	// one-cycle registered request pulses
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pri_irq_reg <= 1'b0;
			sec_irq_reg <= 1'b0;
		end
		else
		begin
			pri_irq_reg <= pri_irq;
			sec_irq_reg <= sec_irq;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	always_comb
	begin
		rdata = '0;
		if (sel_ctrl)
			rdata[CTRL_UNLOCK_BIT] = unlock_reg;
		if (sel_level)
		begin
			rdata[LVL_ENABLE_BIT] = sec_enable_reg;
			rdata[LVL_MODE_BIT]   = sec_mode_reg;
			rdata[LVL_CODE_LSB +: SEC_LEVEL_W] = sec_code_reg;
		end
		if (sel_status)
		begin
			rdata[FLG_PRI_BIT]         = pri_flag_reg;
			rdata[FLG_SEC_BIT]         = sec_flag_reg;
			rdata[STS_PRI_OK_BIT]      = pri_ok_reg;
			rdata[STS_SEC_ACTIVE_BIT]  = sec_active;
			rdata[STS_PRI_RSTMODE_BIT] = pri_rst_mode;
		end
	end

	// captured in the setup cycle, stable through the access phase
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			prdata_out <= '0;
		else if (psel_in & ~penable_in & ~pwrite_in)
			prdata_out <= rdata;
	end

	assign primary_level_out      = pri_level_reg;
	assign secondary_enable_out   = sec_enable_reg;
	assign secondary_level_out    = sec_code_reg;
	assign low_voltage_irq_out    = pri_irq_reg;
	assign voltage_detect_irq_out = sec_irq_reg;

	// ************************************************************
	// assertions
	// ************************************************************
	a_stab_holds_rst: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(state_reg == ST_STAB) |-> internal_rst_out)
		else $error("reset released during power-on stabilisation");

	a_no_supply_rst: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(!pri_ok_reg && (pri_rst_mode || !cpu_run)) |=> internal_rst_out)
		else $error("reset released without primary supply");

	a_pri_low_rst: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(cpu_run && pri_rst_mode && !pri_ok_reg) |=> internal_rst_out)
		else $error("primary low in reset mode gave no reset");

	a_pri_cross_irq: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(cpu_run && !pri_rst_mode && $changed(pri_ok_reg)) |=> low_voltage_irq_out)
		else $error("primary crossing gave no interrupt");

	a_fall_delayed: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(pri_ok_reg) |-> $past(pri_fall_done) && !$past(pri_sync))
		else $error("primary fall taken before the delay");

	a_sec_off_run: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(internal_rst_out) |-> !sec_enable_reg && !written_once_reg)
		else $error("secondary enabled at reset exit");

	a_level_locked: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(cpu_run && !unlock_reg) ##1 cpu_run |-> $stable(sec_code_reg) && $stable(sec_enable_reg))
		else $error("level register changed while locked");

	a_one_rewrite: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(written_once_reg && cpu_run) ##1 cpu_run |-> $stable(sec_code_reg))
		else $error("second level rewrite accepted");

	a_sec_quiet: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!sec_active |-> !sec_irq && !sec_rst_req)
		else $error("secondary detection before stabilisation");

	a_code_range: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sec_code_reg < SEC_LEVEL_COUNT)
		else $error("secondary level code out of range");

	a_sec_rst_clear: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sec_rst_req |=> internal_rst_out ##1 !sec_enable_reg)
		else $error("secondary reset left detector enabled");

	a_flag_set: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		(sec_irq && cpu_run) ##1 cpu_run |-> sec_flag_reg)
		else $error("secondary flag not set by event");

	a_force_mode: assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sec_rst_req |=> pri_rst_mode)
		else $error("primary not forced to reset mode");

endmodule : svdc_top

//--- tb/supply_voltage_detect_control_bench.sv
`timescale 1ns/10ps
module supply_voltage_detect_control_bench
	import svdc_pkg::*;
;
	// shortened delay counts keep the run brief
	localparam int POR_C  = 20;
	localparam int FALL_C = 10;
	localparam int STAB_C = 10;

	// ************************************************************
	// signals
	// ************************************************************
	logic        clk_in;
	logic        sys_rst_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pri_ok;
	logic        sec_ok;
	logic        pri_cmp;
	logic        sec_cmp;
	logic [2:0]  pri_lvl;
	logic        sec_en;
	logic [4:0]  sec_lvl;
	logic        int_rst;
	logic        lv_irq;
	logic        vd_irq;
	logic [31:0] rd;
	logic        err;
	int          fail_count;
	int          num_checks;
	int          lv_cnt;
	int          vd_cnt;
	int          n;

	// ************************************************************
	// design and comparator model
	// ************************************************************
	svdc_top #(.PRI_FALL_CYC(FALL_C), .SEC_STAB_CYC(STAB_C), .POR_STAB_CYC(POR_C)) dut
	(
		.clk_in                 (clk_in),
		.sys_rst_in             (sys_rst_in),
		.boot_option_in         (8'h02),
		.pri_cmp_in             (pri_cmp),
		.sec_cmp_in             (sec_cmp),
		.psel_in                (psel),
		.penable_in             (penable),
		.pwrite_in              (pwrite),
		.paddr_in               (paddr),
		.pwdata_in              (pwdata),
		.prdata_out             (prdata),
		.pready_out             (pready),
		.pslverr_out            (pslverr),
		.primary_level_out      (pri_lvl),
		.secondary_enable_out   (sec_en),
		.secondary_level_out    (sec_lvl),
		.internal_rst_out       (int_rst),
		.low_voltage_irq_out    (lv_irq),
		.voltage_detect_irq_out (vd_irq)
	);

	svdc_cmp_model cmp
	(
		.clk_in      (clk_in),
		.pri_ok_in   (pri_ok),
		.sec_ok_in   (sec_ok),
		.pri_cmp_out (pri_cmp),
		.sec_cmp_out (sec_cmp)
	);

	// ************************************************************
	// clock, event counters, watchdog
	// ************************************************************
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// count one-cycle interrupt pulses
	always @(posedge clk_in)
	begin
		if (lv_irq === 1'b1) lv_cnt++;
		if (vd_irq === 1'b1) vd_cnt++;
	end

	initial
	begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		summarize();
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer: setup, then access until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a wait for pready
		do
			@(posedge clk_in);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// unlock, write the level register, lock again
	task automatic sec_enable(input logic [31:0] d);
		apb(1'b1, DETECT_CTRL_OFS, 32'h1);
		apb(1'b1, LEVEL_SELECT_OFS, d);
		apb(1'b1, DETECT_CTRL_OFS, 32'h0);
	endtask : sec_enable

	// wait, bounded, for reset level (0) or an interrupt count (1, 2)
	task automatic waitfor(input int which, input int target);
		int k;
		k = 0;
		while (k < 300 && !((which == 0 && int_rst === target[0]) ||
			(which == 1 && lv_cnt == target) || (which == 2 && vd_cnt == target)))
		begin
			@(negedge clk_in);
			k++;
		end
		chk(32'(k < 300), 32'h1);
		// hand back on a rising edge so the next stimulus lands there
		@(posedge clk_in);
	endtask : waitfor

	task automatic boot_reset();
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		n = 0;
		while (int_rst !== 1'b0 && n < 500)
		begin
			@(negedge clk_in);
			n++;
		end
	endtask : boot_reset

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// ************************************************************
	// test sequence
	// ************************************************************
	initial
	begin
		sys_rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pri_ok = 1'b1;
		sec_ok = 1'b1;
		fail_count = 0;
		num_checks = 0;
		lv_cnt = 0;
		vd_cnt = 0;
		// power-on: stabilisation plus processing before run
		boot_reset();
		chk(32'(n >= POR_C + RESET_PROC_CYCLES && n < 500), 32'h1);
		chk(32'(pri_lvl), 32'h2);
		chk(32'(sec_en), 32'h0);
		// locked and out-of-range level writes are ignored
		apb(1'b1, LEVEL_SELECT_OFS, 32'h83);
		apb(1'b0, LEVEL_SELECT_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, DETECT_CTRL_OFS, 32'h1);
		apb(1'b1, LEVEL_SELECT_OFS, 32'h92);
		apb(1'b0, LEVEL_SELECT_OFS, 32'h0);
		chk(rd, 32'h0);
		// secondary interrupt mode with supply already low
		sec_ok <= 1'b0;
		sec_enable(32'h83);
		chk(32'(vd_cnt), 32'h0);
		waitfor(2, 1);
		apb(1'b0, LEVEL_SELECT_OFS, 32'h0);
		chk(rd, 32'h83);
		chk(32'(sec_lvl), 32'h3);
		sec_enable(32'h85);
		apb(1'b0, LEVEL_SELECT_OFS, 32'h0);
		chk(rd, 32'h83);
		sec_ok <= 1'b1;
		waitfor(2, 2);
		apb(1'b0, FLAG_STATUS_OFS, 32'h0);
		chk(32'(rd[FLG_SEC_BIT]), 32'h1);
		apb(1'b1, FLAG_CLEAR_OFS, 32'h2);
		apb(1'b0, FLAG_STATUS_OFS, 32'h0);
		chk(32'(rd[FLG_SEC_BIT]), 32'h0);
		// unmapped address answers with an error and zero data
		apb(1'b0, 12'h010, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// primary interrupt mode: delayed fall, then both crossings
		pri_ok <= 1'b0;
		repeat (FALL_C - 2) @(negedge clk_in);
		chk(32'(lv_cnt), 32'h0);
		waitfor(1, 1);
		pri_ok <= 1'b1;
		waitfor(1, 2);
		chk(32'(int_rst), 32'h0);
		apb(1'b0, FLAG_STATUS_OFS, 32'h0);
		chk(32'(rd[FLG_PRI_BIT]), 32'h1);
		// secondary reset mode, after a reset in mid-run
		boot_reset();
		chk(32'(n < 500), 32'h1);
		chk(32'(sec_en), 32'h0);
		sec_enable(32'hc5);
		repeat (30) @(negedge clk_in);
		chk(32'(int_rst), 32'h0);
		@(posedge clk_in);
		sec_ok <= 1'b0;
		waitfor(0, 1);
		waitfor(0, 0);
		apb(1'b0, LEVEL_SELECT_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, FLAG_STATUS_OFS, 32'h0);
		chk(32'(rd[STS_PRI_RSTMODE_BIT]), 32'h1);
		// re-enabling below threshold resets again
		sec_enable(32'hc5);
		waitfor(0, 1);
		waitfor(0, 0);
		// primary now held in reset mode: a fall resets, no interrupt
		sec_ok <= 1'b1;
		pri_ok <= 1'b0;
		waitfor(0, 1);
		pri_ok <= 1'b1;
		waitfor(0, 0);
		chk(32'(lv_cnt), 32'h2);
		summarize();
	end

endmodule : supply_voltage_detect_control_bench

//--- tb/svdc_cmp_model.sv
`timescale 1ns/10ps
module svdc_cmp_model
(
	// clock
	input  wire logic clk_in,
	// supply state chosen by the bench
	input  wire logic pri_ok_in,
	input  wire logic sec_ok_in,
	// comparator levels, high while supply at or above threshold
	output logic      pri_cmp_out,
	output logic      sec_cmp_out
);

	// ************************************************************
	// comparators
	// ************************************************************
	// outputs settle one clock after the supply moves, as an analog stage would
	always_ff @(posedge clk_in)
	begin
		pri_cmp_out <= pri_ok_in;
		sec_cmp_out <= sec_ok_in;
	end

endmodule : svdc_cmp_model
